// File: dv/lfm_host_model.sv
// master controller model: register cycles and self-clearing clear commands
`timescale 1ns/1ps
module lfm_host_model
	import lfm_pkg::*;
(
	// clock
	input wire logic clk,
	// register port
	output logic [7:0] addr,
	output logic [31:0] wdata,
	output logic wr,
	output logic rd,
	input wire logic [31:0] rdata
);
	// ctrl also holds the single short enable, so clears must carry it along
	bit en;
	initial begin
		addr = 8'h00;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
		en = 1'b0;
	end
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		// stale data is garbled once the strobe is gone
		wdata <= ~d;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
	// one write of a 1, never a write of 0 to release it
	task automatic clear(input int b);
		wr_reg(ADDR_CTRL, 32'((int'(en) << CTRL_SINGLE_SHORT_DETECT_ENABLE) | (1 << b)));
	endtask
endmodule

// File: dv/tb_lfm_monitor.sv
// self-checking bench of the led fault monitor
`timescale 1ns/1ps
module tb_lfm_monitor;
	import lfm_pkg::*;
	localparam int PC = 20;
	logic clk, rst, wr, rd, c_warn, c_tsd1, c_tsd2, c_low, led_en, reg_en, fp_i, fp_o, fp_oe;
	logic [7:0] addr, tha, thb, lfsr, fa;
	logic [31:0] wdata, rdata, d;
	logic [4:0] lowsup;
	logic [NCH-1:0] pwm_on, c_open, c_gs, c_gok, c_ss, c_sok, tsel;
	logic [31:0] cfg [4];
	int miscompares, n_tests, ch, n;
	bit exp_por, exp_warn, exp_tsd, exp_out;
	// open-drain fault line with pull-up
	assign fp_i = fp_oe ? fp_o : 1'b1;
	lfm_host_model host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	lfm_monitor #(.PULSE_CYCLES(PC), .BLANK_STEP(1), .OPEN_DEG(3), .SHORT_DEG(3), .SLS_DEG(3)) dut (
		.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.pwm_on(pwm_on), .cmp_warn(c_warn), .cmp_tsd1(c_tsd1), .cmp_tsd2(c_tsd2), .cmp_low_supply(c_low),
		.cmp_open(c_open), .cmp_ground_short(c_gs), .cmp_ground_ok(c_gok), .cmp_single_short(c_ss),
		.cmp_single_ok(c_sok), .low_supply_threshold_cfg(lowsup), .single_short_threshold_a(tha),
		.single_short_threshold_b(thb), .channel_single_short_thresh_select(tsel),
		.led_channel_output_en(led_en), .internal_regulator_en(reg_en),
		.fault_pin_i(fp_i), .fault_pin_o(fp_o), .fault_pin_oe(fp_oe));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic logic [31:0] est();
		int o;
		o = exp_por | exp_warn | exp_tsd | exp_out;
		return 32'(o | exp_por << 1 | exp_warn << 2 | exp_tsd << 3 | exp_out << 4);
	endfunction
	function automatic logic sig(input int w);
		return w == 0 ? fp_oe : (w == 1 ? led_en : reg_en);
	endfunction
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic chk_reg(input string nm, input logic [7:0] a, input logic [31:0] exp);
		host.rd_reg(a, d);
		check(nm, d, exp);
	endtask
	// bounded wait for an output to go high
	task automatic wait_for(input int w);
		int i;
		i = 0;
		while (i < 300 && sig(w) !== 1'b1) begin
			@(negedge clk);
			i++;
		end
		if (i == 300) begin
			check("wait_timeout", 32'h1, 32'h0);
			end_sim();
		end
	endtask
	task automatic high_len(input int lim);
		n = 0;
		while (fp_oe === 1'b1 && n < lim) begin
			n++;
			@(negedge clk);
		end
	endtask
	task automatic set_cond(input int k, input int c, input logic v);
		@(posedge clk);
		case (k)
			0: c_open[c] <= v;
			1: begin
				c_gs[c] <= v;
				c_gok[c] <= ~v;
			end
			default: begin
				c_ss[c] <= v;
				c_sok[c] <= ~v;
			end
		endcase
	endtask
	task automatic pulse_cond(input int k, input int c, input logic p, input int len);
		@(posedge clk);
		pwm_on <= {NCH{p}};
		set_cond(k, c, 1'b1);
		repeat (len) @(posedge clk);
		set_cond(k, c, 1'b0);
		repeat (12) @(posedge clk);
		pwm_on <= '1;
	endtask
	initial begin
		{rst, wr, rd, c_warn, c_tsd1, c_tsd2, c_low} = 7'b1000000;
		{pwm_on, c_open, c_gs, c_ss} = '0;
		{c_gok, c_sok} = '1;
		lfsr = 8'h60;
		{miscompares, n_tests} = 0;
		{exp_warn, exp_tsd, exp_out, exp_por} = 4'b0001;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		check("reset_pins", {led_en, reg_en, fp_oe, fp_o}, 4'hC);
		chk_reg("status_rst", ADDR_STATUS, est());
		host.clear(CTRL_PCLR);
		exp_por = 0;
		chk_reg("status_pclr", ADDR_STATUS, est());
		chk_reg("ctrl_selfclr", ADDR_CTRL, 32'h0);
		host.wr_reg(ADDR_STATUS, 32'h1F);
		chk_reg("status_ro", ADDR_STATUS, est());
		host.wr_reg(8'h28, 32'hFFFFFFFF);
		chk_reg("unmapped", 8'h28, 32'h0);
		for (int i = 0; i < 4; i++) begin
			for (int j = 0; j < 4; j++) begin
				lfsr = lfsr_next(lfsr);
				cfg[i] = {cfg[i][23:0], lfsr};
			end
			cfg[i] &= (i == 0) ? 32'h1F : ((i == 3) ? 32'hFFFFFF : 32'hFF);
			host.wr_reg(ADDR_LOWSUP + 8'(4 * i), cfg[i]);
			chk_reg("cfg_rd", ADDR_LOWSUP + 8'(4 * i), cfg[i]);
		end
		check("cfg_ports", 32'({lowsup, tha, thb}), 32'({cfg[0][4:0], cfg[1][7:0], cfg[2][7:0]}));
		check("sel_port", 32'(tsel), 32'(cfg[3][23:0]));
		host.wr_reg(ADDR_BLANK, 32'h2);
		chk_reg("blank", ADDR_BLANK, 32'h2);
		@(posedge clk);
		c_warn <= 1'b1;
		wait_for(0);
		// the pulled-up line must actually read low while driven
		check("pin_low", 32'(fp_i), 32'h0);
		high_len(100);
		check("warn_pulse", n, PC);
		exp_warn = 1;
		@(posedge clk);
		c_warn <= 1'b0;
		chk_reg("warn_latched", ADDR_STATUS, est());
		host.clear(CTRL_FCLR);
		exp_warn = 0;
		chk_reg("warn_clr", ADDR_STATUS, est());
		@(posedge clk);
		c_tsd1 <= 1'b1;
		wait_for(0);
		high_len(60);
		check("tsd1_hold", n, 60);
		check("tsd1_drv", led_en, 1'b0);
		exp_tsd = 1;
		chk_reg("tsd1_flag", ADDR_STATUS, est());
		@(posedge clk);
		c_tsd1 <= 1'b0;
		wait_for(1);
		@(negedge clk);
		check("tsd1_release", fp_oe, 1'b0);
		chk_reg("tsd1_latched", ADDR_STATUS, est());
		host.clear(CTRL_FCLR);
		exp_tsd = 0;
		chk_reg("tsd1_clr", ADDR_STATUS, est());
		pwm_on <= '1;
		for (int k = 0; k < 3; k++) begin
			lfsr = lfsr_next(lfsr);
			ch = lfsr % NCH;
			fa = ADDR_OPEN + 8'(4 * k);
			if (k == 2) begin
				pulse_cond(k, ch, 1'b1, 20);
				chk_reg("sls_off", fa, 32'h0);
				host.en = 1;
				host.wr_reg(ADDR_CTRL, 32'h4);
			end
			pulse_cond(k, ch, 1'b0, 20);
			chk_reg("pwm_off", fa, 32'h0);
			pulse_cond(k, ch, 1'b1, 4);
			chk_reg("short_on", fa, 32'h0);
			set_cond(k, ch, 1'b1);
			wait_for(0);
			high_len(100);
			check("chan_pulse", n, PC);
			exp_out = 1;
			chk_reg("chan_flag", fa, 32'h1 << ch);
			chk_reg("chan_status", ADDR_STATUS, est());
			check("no_action", led_en, 1'b1);
			host.clear(CTRL_FCLR);
			chk_reg("clr_present", fa, 32'h1 << ch);
			set_cond(k, ch, 1'b0);
			repeat (20) @(posedge clk);
			host.clear(CTRL_FCLR);
			exp_out = 0;
			chk_reg("chan_clr", ADDR_STATUS, est());
			c_low <= 1'b1;
			pulse_cond(k, ch, 1'b1, 20);
			chk_reg("low_sup", fa, (k == 1) ? 32'h1 << ch : 32'h0);
			c_low <= 1'b0;
			host.clear(CTRL_FCLR);
			chk_reg("low_clr", fa, 32'h0);
		end
		@(posedge clk);
		c_tsd2 <= 1'b1;
		repeat (6) @(negedge clk);
		check("tsd2_pins", {reg_en, led_en, fp_oe}, 3'b001);
		@(posedge clk);
		c_tsd2 <= 1'b0;
		wait_for(2);
		@(negedge clk);
		check("tsd2_restart", 32'({fp_oe, lowsup, tha, thb}), 32'h0);
		check("tsd2_sel", 32'(tsel), 32'h0);
		check("pin_high", 32'(fp_i), 32'h1);
		exp_por = 1;
		host.en = 0;
		chk_reg("tsd2_por", ADDR_STATUS, est());
		host.clear(CTRL_PCLR);
		exp_por = 0;
		chk_reg("tsd2_pclr", ADDR_STATUS, est());
		end_sim();
	end
endmodule

// File: verilog/lfm_monitor.sv
// fault flag latching and fault pin reporting for the led driver
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
// How it works
// - warning trip sets warning and summary flags, pulses fault pin 50 us.
// - flags latch; fault clear command clears warning and summary, self-clearing.
// - first overtemp disables drivers, holds pin low, sets overtemp and summary.
// - overtemp gone re-enables drivers, releases pin; flags stay until cleared.
// - second overtemp stops regulator, holds pin; recovery is full reset, power-on flag set.
// - power-on clear command clears power-on and summary flags, self-clearing.
// - open check only during on-time after blanking plus open deglitch.
// - blanking time comes from a writable configuration register.
// - supply below low threshold: no open detection or reporting.
// - qualified open sets channel, any-output, summary flags; pulses pin 50 us.
// - channel faults are only reported, never acted upon.
// - ground short check only during on-time after blanking plus short deglitch.
// - ground short sets channel, any-output, summary flags; pulses pin 50 us.
// - fault and recovery both need persistence beyond blanking plus deglitch; low supply forces open and single short recovery at once.
// - single short detection only when its enable bit is 1.
// - single short only during on-time, after blank plus deglitch, supply good.
// - per-channel select bit picks threshold a (0) or b (1).
// - thresholds are 8-bit codes, 2.5 V base, 125 mV steps.
// - single short sets flags; recovery needs threshold plus 275 mV.
module lfm_monitor
	import lfm_pkg::*;
#(
	parameter int PULSE_CYCLES = PULSE_CYC,
	parameter int BLANK_STEP = BLANK_STEP_CYC,
	parameter int OPEN_DEG = OPEN_DEG_CYC,
	parameter int SHORT_DEG = SHORT_DEG_CYC,
	parameter int SLS_DEG = SLS_DEG_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// pwm on status, same clock
	input wire logic [NCH-1:0] pwm_on,
	// asynchronous analog comparators
	input wire logic cmp_warn,
	input wire logic cmp_tsd1,
	input wire logic cmp_tsd2,
	input wire logic cmp_low_supply,
	input wire logic [NCH-1:0] cmp_open,
	input wire logic [NCH-1:0] cmp_ground_short,
	input wire logic [NCH-1:0] cmp_ground_ok,
	input wire logic [NCH-1:0] cmp_single_short,
	input wire logic [NCH-1:0] cmp_single_ok,
	// analog settings
	output logic [4:0] low_supply_threshold_cfg,
	output logic [7:0] single_short_threshold_a,
	output logic [7:0] single_short_threshold_b,
	output logic [NCH-1:0] channel_single_short_thresh_select,
	output logic led_channel_output_en,
	output logic internal_regulator_en,
	// open-drain fault pin
	input wire logic fault_pin_i,
	output logic fault_pin_o,
	output logic fault_pin_oe
);
	if (PULSE_CYCLES < 1 || PULSE_CYCLES >= 2 ** CNT_W) begin : g_bad_pulse
		$error("pulse length does not fit the pulse counter");
	end
	if (BLANK_STEP < 1 || (255 * BLANK_STEP + OPEN_DEG + SHORT_DEG + SLS_DEG) >= 2 ** LIM_W) begin : g_bad_lim
		$error("blanking and deglitch do not fit the qualifier counter");
	end

	localparam logic [CNT_W-1:0] PULSE_LOAD = CNT_W'(PULSE_CYCLES);

	lfm_state_t q;
	lfm_state_t n;
	lfm_cmp_t cmp;
	logic [NCH-1:0] open_det;
	logic [NCH-1:0] open_act;
	logic [NCH-1:0] short_det;
	logic [NCH-1:0] short_act;
	logic [NCH-1:0] sls_det;
	logic [NCH-1:0] sls_act;
	logic [LIM_W-1:0] lim_open;
	logic [LIM_W-1:0] lim_short;
	logic [LIM_W-1:0] lim_sls;
	logic clr_f;
	logic clr_p;
	logic any_out;
	logic summary;
	logic events;
	logic hold_on;

	function automatic logic ctrl_bit(input logic [7:0] a, input logic [31:0] d, input logic w, input int b);
		ctrl_bit = w && a == ADDR_CTRL && d[b];
	endfunction

	lfm_sync #(
		.W(CMP_W)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.d({cmp_warn, cmp_tsd1, cmp_tsd2, cmp_low_supply, cmp_open, cmp_ground_short, cmp_ground_ok,
			cmp_single_short, cmp_single_ok}),
		.q(cmp)
	);

	// blanking from the register plus each deglitch time
	always_comb begin
		lim_open = LIM_W'(q.blank_cfg * BLANK_STEP + OPEN_DEG);
		lim_short = LIM_W'(q.blank_cfg * BLANK_STEP + SHORT_DEG);
		lim_sls = LIM_W'(q.blank_cfg * BLANK_STEP + SLS_DEG);
	end

	// drivers forced off by overtemp never count as on-time
	assign hold_on = cmp.tsd2;

	for (genvar i = 0; i < NCH; i++) begin : g_ch
		lfm_qual u_open (
			.clk(clk),
			.rst(rst),
			.hold(hold_on),
			.arm(pwm_on[i] & ~cmp.tsd1 & ~cmp.low_sup),
			.cond(cmp.open_det[i]),
			.recov(~cmp.open_det[i]),
			.force_recov(cmp.low_sup),
			.limit(lim_open),
			.detect(open_det[i]),
			.active(open_act[i])
		);
		lfm_qual u_short (
			.clk(clk),
			.rst(rst),
			.hold(hold_on),
			.arm(pwm_on[i] & ~cmp.tsd1),
			.cond(cmp.short_det[i]),
			.recov(cmp.short_ok[i]),
			.force_recov(1'b0),
			.limit(lim_short),
			.detect(short_det[i]),
			.active(short_act[i])
		);
		lfm_qual u_sls (
			.clk(clk),
			.rst(rst),
			.hold(hold_on),
			.arm(pwm_on[i] & ~cmp.tsd1 & ~cmp.low_sup & q.single_short_detect_enable),
			.cond(cmp.sls_det[i]),
			.recov(cmp.sls_ok[i]),
			.force_recov(cmp.low_sup | ~q.single_short_detect_enable),
			.limit(lim_sls),
			.detect(sls_det[i]),
			.active(sls_act[i])
		);
	end

	// self-clearing commands live only in the write cycle
	assign clr_f = ctrl_bit(addr, wdata, wr, CTRL_FCLR);
	assign clr_p = ctrl_bit(addr, wdata, wr, CTRL_PCLR);
	assign any_out = |{q.channel_open_flag, q.channel_ground_short_flag, q.channel_single_short_flag};
	assign summary = q.thermal_warning_flag | q.overtemp_flag | q.por_flag | any_out;
	assign events = (cmp.warn & ~q.warn_q) | (|open_det) | (|short_det) | (|sls_det);

	always_comb begin
		n = q;
		n.warn_q = cmp.warn;
		// set wins over clear while the condition is still there
		n.thermal_warning_flag = (q.thermal_warning_flag & ~clr_f) | cmp.warn;
		n.overtemp_flag = (q.overtemp_flag & ~clr_f) | cmp.tsd1;
		n.por_flag = q.por_flag & ~clr_p;
		// a flag whose fault has not recovered cannot be cleared
		n.channel_open_flag = (q.channel_open_flag & ~({NCH{clr_f}} & ~open_act)) | open_det;
		n.channel_ground_short_flag = (q.channel_ground_short_flag & ~({NCH{clr_f}} & ~short_act)) | short_det;
		n.channel_single_short_flag = (q.channel_single_short_flag & ~({NCH{clr_f}} & ~sls_act)) | sls_det;
		// pulse counter, restarted by each new event
		if (events) begin
			n.pulse_cnt = PULSE_LOAD;
		end else if (q.pulse_cnt != '0) begin
			n.pulse_cnt = q.pulse_cnt - 1'b1;
		end
		n.pin_oe = cmp.tsd1 | cmp.tsd2 | (n.pulse_cnt != '0);
		// only overtemp acts on the outputs, channel faults never do
		n.drv_en = ~cmp.tsd1;
		n.reg_en = 1'b1;
		if (wr) begin
			case (addr)
				ADDR_CTRL: begin
					n.single_short_detect_enable = wdata[CTRL_SINGLE_SHORT_DETECT_ENABLE];
				end
				ADDR_BLANK: begin
					n.blank_cfg = wdata[7:0];
				end
				ADDR_LOWSUP: begin
					n.low_supply_threshold_cfg = wdata[4:0];
				end
				ADDR_STH_A: begin
					n.single_short_threshold_a = wdata[7:0];
				end
				ADDR_STH_B: begin
					n.single_short_threshold_b = wdata[7:0];
				end
				ADDR_STH_SEL: begin
					n.channel_single_short_thresh_select = wdata[NCH-1:0];
				end
				default: begin
				end
			endcase
		end
		n.rdata = '0;
		if (rd) begin
			case (addr)
				ADDR_CTRL: n.rdata[CTRL_SINGLE_SHORT_DETECT_ENABLE] = q.single_short_detect_enable;
				ADDR_BLANK: n.rdata[7:0] = q.blank_cfg;
				ADDR_LOWSUP: n.rdata[4:0] = q.low_supply_threshold_cfg;
				ADDR_STH_A: n.rdata[7:0] = q.single_short_threshold_a;
				ADDR_STH_B: n.rdata[7:0] = q.single_short_threshold_b;
				ADDR_STH_SEL: n.rdata[NCH-1:0] = q.channel_single_short_thresh_select;
				ADDR_STATUS: begin
					n.rdata[ST_SUM] = summary;
					n.rdata[ST_POR] = q.por_flag;
					n.rdata[ST_WARN] = q.thermal_warning_flag;
					n.rdata[ST_TSD] = q.overtemp_flag;
					n.rdata[ST_OUT] = any_out;
				end
				ADDR_OPEN: n.rdata[NCH-1:0] = q.channel_open_flag;
				ADDR_SHORT: n.rdata[NCH-1:0] = q.channel_ground_short_flag;
				ADDR_SLS: n.rdata[NCH-1:0] = q.channel_single_short_flag;
				default: n.rdata = '0;
			endcase
		end
		// regulator off means everything restarts from defaults
		if (cmp.tsd2) begin
			n = ST_RST;
			n.reg_en = 1'b0;
			n.drv_en = 1'b0;
			n.pin_oe = 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= ST_RST;
		end else begin
			q <= n;
		end
	end

	assign rdata = q.rdata;
	assign low_supply_threshold_cfg = q.low_supply_threshold_cfg;
	assign single_short_threshold_a = q.single_short_threshold_a;
	assign single_short_threshold_b = q.single_short_threshold_b;
	assign channel_single_short_thresh_select = q.channel_single_short_thresh_select;
	assign led_channel_output_en = q.drv_en;
	assign internal_regulator_en = q.reg_en;
	assign fault_pin_o = 1'b0;
	assign fault_pin_oe = q.pin_oe;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_warn_edge;
		cmp.warn && !q.warn_q && !cmp.tsd2;
	endsequence

	sequence s_pulse_started;
		q.pulse_cnt == PULSE_LOAD && fault_pin_oe;
	endsequence

	a_warn_flag_set: assert property (s_warn_edge |=> q.thermal_warning_flag && summary)
		else $error("warning did not set its flags");
	a_warn_pulse_start: assert property (s_warn_edge |=> s_pulse_started ##1 fault_pin_oe)
		else $error("warning did not start a fault pin pulse");
	a_fault_clear_cmd: assert property (clr_f && !cmp.warn && !cmp.tsd2 |=> !q.thermal_warning_flag)
		else $error("fault clear did not clear the warning flag");
	a_tsd_drivers_off: assert property (cmp.tsd1 |=> !led_channel_output_en && fault_pin_oe && q.overtemp_flag)
		else $error("overtemp did not disable drivers");
	a_tsd_recovery: assert property ($fell(cmp.tsd1) && !cmp.tsd2 && !clr_f |=> led_channel_output_en && q.overtemp_flag)
		else $error("overtemp recovery wrong");
	a_hot_reset: assert property (cmp.tsd2 |=> !internal_regulator_en && fault_pin_oe && q.por_flag && q.blank_cfg == '0)
		else $error("second overtemp did not hold reset");
	a_por_clear: assert property (clr_p && !cmp.tsd2 |=> !q.por_flag)
		else $error("power-on clear did not clear the flag");
	a_open_low_supply: assert property (cmp.low_sup |=> open_det == '0 && sls_det == '0)
		else $error("open or single short reported at low supply");
	a_sls_disabled: assert property (!q.single_short_detect_enable |=> sls_det == '0)
		else $error("single short reported while disabled");
	a_pulse_holds_pin: assert property (q.pulse_cnt != '0 |-> fault_pin_oe)
		else $error("fault pin released during a pulse");
	a_pulse_counts_down: assert property (q.pulse_cnt != '0 && !events && !cmp.tsd2 |=> q.pulse_cnt == $past(q.pulse_cnt) - 1'b1)
		else $error("pulse counter did not count down");
	a_clear_set_wins: assert property (clr_f && cmp.tsd1 && !cmp.tsd2 |=> q.overtemp_flag)
		else $error("fault present during clear was lost");
	a_read_one_cycle: assert property (!rd |=> rdata == '0)
		else $error("read data outside the answer cycle");
endmodule

// File: verilog/lfm_pkg.sv
// constants, register map and carrier types of the led fault monitor
package lfm_pkg;
	localparam int NCH = 24;
	localparam int CLK_MHZ = 100;
	// fault pin pulse width
	localparam int PULSE_US = 50;
	localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
	localparam int CNT_W = 13;
	// blanking step and deglitch times, plain defaults
	localparam int BLANK_STEP_NS = 1000;
	localparam int BLANK_STEP_CYC = (BLANK_STEP_NS * CLK_MHZ + 999) / 1000;
	localparam int OPEN_DEG_NS = 5000;
	localparam int OPEN_DEG_CYC = (OPEN_DEG_NS * CLK_MHZ + 999) / 1000;
	localparam int SHORT_DEG_NS = 5000;
	localparam int SHORT_DEG_CYC = (SHORT_DEG_NS * CLK_MHZ + 999) / 1000;
	localparam int SLS_DEG_NS = 5000;
	localparam int SLS_DEG_CYC = (SLS_DEG_NS * CLK_MHZ + 999) / 1000;
	localparam int LIM_W = 20;
	// single short threshold code: base plus code times step
	localparam int SLS_BASE_MV = 2500;
	localparam int SLS_STEP_MV = 125;
	localparam int SLS_HYS_MV = 275;
	// register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_BLANK = 8'h04;
	localparam logic [7:0] ADDR_LOWSUP = 8'h08;
	localparam logic [7:0] ADDR_STH_A = 8'h0C;
	localparam logic [7:0] ADDR_STH_B = 8'h10;
	localparam logic [7:0] ADDR_STH_SEL = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;
	localparam logic [7:0] ADDR_OPEN = 8'h1C;
	localparam logic [7:0] ADDR_SHORT = 8'h20;
	localparam logic [7:0] ADDR_SLS = 8'h24;
	// control bits
	localparam int CTRL_FCLR = 0;
	localparam int CTRL_PCLR = 1;
	localparam int CTRL_SINGLE_SHORT_DETECT_ENABLE = 2;
	// status bits
	localparam int ST_SUM = 0;
	localparam int ST_POR = 1;
	localparam int ST_WARN = 2;
	localparam int ST_TSD = 3;
	localparam int ST_OUT = 4;
	// synchronised analog comparator results
	typedef struct packed {
		logic warn;
		logic tsd1;
		logic tsd2;
		logic low_sup;
		logic [NCH-1:0] open_det;
		logic [NCH-1:0] short_det;
		logic [NCH-1:0] short_ok;
		logic [NCH-1:0] sls_det;
		logic [NCH-1:0] sls_ok;
	} lfm_cmp_t;
	localparam int CMP_W = $bits(lfm_cmp_t);
	typedef struct packed {
		logic thermal_warning_flag;
		logic overtemp_flag;
		logic por_flag;
		logic [NCH-1:0] channel_open_flag;
		logic [NCH-1:0] channel_ground_short_flag;
		logic [NCH-1:0] channel_single_short_flag;
		logic single_short_detect_enable;
		logic [7:0] blank_cfg;
		logic [4:0] low_supply_threshold_cfg;
		logic [7:0] single_short_threshold_a;
		logic [7:0] single_short_threshold_b;
		logic [NCH-1:0] channel_single_short_thresh_select;
		logic [CNT_W-1:0] pulse_cnt;
		logic warn_q;
		logic pin_oe;
		logic drv_en;
		logic reg_en;
		logic [31:0] rdata;
	} lfm_state_t;
	localparam lfm_state_t ST_RST = '{por_flag: 1'b1, drv_en: 1'b1, reg_en: 1'b1, default: '0};
endpackage

// File: verilog/lfm_qual.sv
// persistence qualifier: fault and recovery each need more than limit cycles; force_recov recovers at once, hold clears all
`timescale 1ns/1ps
module lfm_qual
	import lfm_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// conditions
	input wire logic hold,
	input wire logic arm,
	input wire logic cond,
	input wire logic recov,
	input wire logic force_recov,
	input wire logic [LIM_W-1:0] limit,
	// result
	output logic detect,
	output logic active
);
	typedef struct packed {
		logic [LIM_W-1:0] cnt;
		logic active;
		logic det;
	} lfm_qual_st_t;
	lfm_qual_st_t st_reg;
	lfm_qual_st_t st_next;

	always_comb begin
		st_next = st_reg;
		st_next.det = 1'b0;
		if (hold) begin
			st_next = '0;
		end else if (force_recov) begin
			st_next.active = 1'b0;
			st_next.cnt = '0;
		end else if (arm && (st_reg.active ? recov : cond)) begin
			// any gap in the on-time or the condition restarts the count
			if (st_reg.cnt >= limit) begin
				st_next.cnt = '0;
				st_next.active = ~st_reg.active;
				st_next.det = ~st_reg.active;
			end else begin
				st_next.cnt = st_reg.cnt + 1'b1;
			end
		end else begin
			st_next.cnt = '0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign detect = st_reg.det;
	assign active = st_reg.active;
endmodule

// File: verilog/lfm_sync.sv
// two flip-flop synchroniser for a bus of asynchronous levels
`timescale 1ns/1ps
module lfm_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} lfm_sync_st_t;
	lfm_sync_st_t st_reg;
	lfm_sync_st_t st_next;

	always_comb begin
		st_next.s1 = d;
		st_next.s2 = st_reg.s1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign q = st_reg.s2;
endmodule
